//--- src/mcbi_pkg.sv
// mcbi_pkg: shared constants and carrier types for the multiplexed cpu bus interface
// assumes a single 100 MHz clock domain; the bus cycle is five clock phases long
package mcbi_pkg;
  localparam int ADDR_W          = 13;
  localparam int DATA_W          = 8;
  localparam int UPPER_W         = 5;
  localparam int BUS_DIV         = 5;
  localparam int ADDR_SPACE      = 8192;
  localparam int INT_LIMIT       = 128;
  localparam logic [7:0] RESET_DATA = 8'h00;

  // phase indices inside one bus cycle
  localparam logic [2:0] PH_ADDR  = 3'h0;
  localparam logic [2:0] PH_GAP   = 3'h1;
  localparam logic [2:0] PH_DATA0 = 3'h2;
  localparam logic [2:0] PH_DATA1 = 3'h3;
  localparam logic [2:0] PH_IDLE  = 3'h4;
  localparam logic [2:0] PH_LAST  = 3'h4;

  typedef enum logic {
    MCBI_READ  = 1'b1,
    MCBI_WRITE = 1'b0
  } mcbi_dir_e;

  // one cpu request: address, direction, write data, opcode fetch flag
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              is_read;
    logic [DATA_W-1:0] wdata;
    logic              fetch;
  } mcbi_req_s;

  localparam int REQ_W = $bits(mcbi_req_s);
endpackage : mcbi_pkg

//--- src/mcbi_fifo.sv
// mcbi_fifo: small synchronous valid/ready fifo with parameter width and depth
// assumes both sides on clk; full and empty are exact
`timescale 1ns/100ps
module mcbi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("mcbi_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule : mcbi_fifo

//--- src/mcbi_bus.sv
// mcbi_bus: external multiplexed bus interface of an 8-bit processor
// assumes the cpu core queues requests through a valid/ready port; halt and idle come from the core
// Notes on behaviour
// R1 - pulse address strobe while low address valid
// R2 - outside logic latches low address on strobe
// R3 - address strobe at clock/5, frozen in halt/idle
// R4 - data strobe on every transfer, internal too
// R5 - data strobe at clock/5 outside halt/idle
// R6 - direction high read, low write, valid ahead
// R7 - low lines: address at strobe, then data
// R8 - low lines driven on writes, released on reads
// R9 - upper five address bits on dedicated lines
// R10 - fetch indicator overlaps fetch data strobe
// R11 - active-low reset clears internal state
// R12 - internal reads ignore external data lines
// R13 - 8192 byte space, internal and external regions
// R14 - address phase ends before data phase starts
`timescale 1ns/100ps
module mcbi_bus
  import mcbi_pkg::*;
#(
  parameter int DEPTH = 4
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        reset_pin_n,
  input  wire logic                        halt_mode,
  input  wire logic                        idle_mode,
  input  wire mcbi_pkg::mcbi_req_s         req,
  input  wire logic                        req_valid,
  output logic                             req_ready,
  output logic      [mcbi_pkg::DATA_W-1:0] rdata,
  output logic                             rdata_valid,
  input  wire logic [mcbi_pkg::DATA_W-1:0] int_rdata,
  output logic                             int_sel,
  output logic                             cpu_reset,
  output logic                             address_latch_strobe,
  output logic                             data_transfer_strobe,
  output logic                             rw_n,
  output logic                             opcode_fetch_indicator,
  output logic      [mcbi_pkg::UPPER_W-1:0] upper_address_lines,
  output logic      [mcbi_pkg::DATA_W-1:0] muxed_low_addr_data_lines_o,
  output logic                             muxed_low_addr_data_lines_oe,
  input  wire logic [mcbi_pkg::DATA_W-1:0] muxed_low_addr_data_lines_i
);
  import mcbi_pkg::*;

  initial begin
    if (BUS_DIV != 5 || DEPTH < 2) $error("mcbi_bus needs a five-phase cycle and a fifo of two or more");
  end

  typedef enum logic [1:0] {ST_RUN, ST_FROZEN} mcbi_state_e;

  // reset pin comes from outside: three stages, change taken when stages two and three agree
  logic [2:0]  rst_sync_reg;
  logic        rst_pin_low_reg;
  logic        int_rst;
  logic [2:0]  phase_reg;
  logic [2:0]  phase_next;
  mcbi_state_e state_reg;
  mcbi_req_s   cur_reg;
  logic        cur_valid_reg;
  logic        low_power;
  mcbi_req_s   q_data;
  logic        q_valid;
  logic        q_ready;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        cycle_end;
  logic        is_internal;
  logic [DATA_W-1:0] rdata_reg;
  logic        rdata_valid_reg;
  logic        as_reg;
  logic        ds_reg;
  logic        rw_reg;
  logic        lf_reg;
  logic [UPPER_W-1:0] up_reg;
  logic [DATA_W-1:0]  low_reg;
  logic        oe_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_sync_reg    <= 3'h0;
      rst_pin_low_reg <= 1'b1;
    end else begin
      rst_sync_reg <= {rst_sync_reg[1:0], reset_pin_n};
      if (rst_sync_reg[2] == rst_sync_reg[1]) rst_pin_low_reg <= ~rst_sync_reg[2];
    end
  end

  assign int_rst   = sys_rst || rst_pin_low_reg; // see R11
  assign cpu_reset = rst_pin_low_reg;
  // refuse requests while the fifo is held in reset, otherwise a handshake would complete and be lost
  assign fifo_in_valid = req_valid && !int_rst;
  assign req_ready     = fifo_in_ready && !int_rst; // see R11

  mcbi_fifo #(
    .WIDTH (REQ_W),
    .DEPTH (DEPTH)
  ) u_req_fifo (
    .clk       (clk),
    .sys_rst   (int_rst),
    .in_data   (req),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (q_data),
    .out_valid (q_valid),
    .out_ready (q_ready)
  );

  // strobes stop in halt and idle; a cycle in flight freezes where it stands
  assign low_power  = halt_mode || idle_mode; // see R3, R5
  assign phase_next = (phase_reg == PH_LAST) ? PH_ADDR : phase_reg + 3'h1;
  assign cycle_end  = !low_power && (phase_reg == PH_LAST);
  assign q_ready    = cycle_end; // back-pressure: one request taken per five clocks
  // space is 8192 bytes; the first 128 are on chip
  assign is_internal = cur_reg.addr < ADDR_W'(INT_LIMIT); // see R13

  always_ff @(posedge clk) begin
    if (int_rst) begin
      state_reg     <= ST_RUN;
      phase_reg     <= PH_ADDR;
      cur_valid_reg <= 1'b0;
      cur_reg       <= '0;
    end else begin
      // the phase moves on the very edge that low power ends, in step with the output registers
      if (!low_power) begin
        phase_reg <= phase_next;
        if (cycle_end) begin
          cur_reg       <= q_data;
          cur_valid_reg <= q_valid;
        end
      end
      case (state_reg)
        ST_RUN: begin
          if (low_power) state_reg <= ST_FROZEN;
        end
        ST_FROZEN: begin
          if (!low_power) state_reg <= ST_RUN;
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // output registers; strobes run even with no request so the bus keeps its clock/5 rhythm
  always_ff @(posedge clk) begin
    if (int_rst) begin
      as_reg <= 1'b0;
      ds_reg <= 1'b0;
      rw_reg <= 1'b1;
      lf_reg <= 1'b0;
      up_reg <= '0;
      low_reg <= RESET_DATA;
      oe_reg <= 1'b0;
    end else if (!low_power) begin
      as_reg <= (phase_next == PH_ADDR); // see R1, R3
      ds_reg <= (phase_next == PH_DATA0) || (phase_next == PH_DATA1); // see R4, R5, R14
      if (phase_next == PH_ADDR) begin
        rw_reg  <= cycle_end ? (q_valid ? q_data.is_read : 1'b1) : rw_reg; // see R6
        up_reg  <= q_data.addr[ADDR_W-1 -: UPPER_W]; // see R9
        low_reg <= q_data.addr[DATA_W-1:0]; // see R7
        oe_reg  <= 1'b1;
        lf_reg  <= 1'b0;
      end else if (phase_next == PH_GAP) begin
        oe_reg <= 1'b0; // see R14
      end else if (phase_next == PH_DATA0) begin
        low_reg <= cur_reg.wdata; // see R7
        oe_reg  <= cur_valid_reg && !cur_reg.is_read; // see R8
        lf_reg  <= cur_valid_reg && cur_reg.fetch && cur_reg.is_read; // see R10
      end else if (phase_next == PH_IDLE) begin
        oe_reg <= 1'b0;
        lf_reg <= 1'b0;
      end
    end else begin
      as_reg <= 1'b0;
      ds_reg <= 1'b0;
      lf_reg <= 1'b0; // see R10
    end
  end

  // read data captured at the end of the data strobe
  always_ff @(posedge clk) begin
    if (int_rst) begin
      rdata_reg       <= RESET_DATA;
      rdata_valid_reg <= 1'b0;
    end else begin
      rdata_valid_reg <= 1'b0;
      if (!low_power && phase_reg == PH_DATA1 && cur_valid_reg && cur_reg.is_read) begin
        rdata_reg       <= is_internal ? int_rdata : muxed_low_addr_data_lines_i; // see R12
        rdata_valid_reg <= 1'b1;
      end
    end
  end

  assign int_sel                      = cur_valid_reg && is_internal && ds_reg;
  assign rdata                        = rdata_reg;
  assign rdata_valid                  = rdata_valid_reg;
  assign address_latch_strobe         = as_reg;
  assign data_transfer_strobe         = ds_reg;
  assign rw_n                         = rw_reg;
  assign opcode_fetch_indicator       = lf_reg;
  assign upper_address_lines          = up_reg;
  assign muxed_low_addr_data_lines_o  = low_reg;
  assign muxed_low_addr_data_lines_oe = oe_reg;
endmodule : mcbi_bus

//--- bench/mcbi_bus_assertions.sv
// port-level timing checker for mcbi_bus
// assumes it is bound to every mcbi_bus instance and sees its ports only
`timescale 1ns/100ps
module mcbi_bus_assertions
  import mcbi_pkg::*;
(
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic               reset_pin_n,
  input wire logic               halt_mode,
  input wire logic               idle_mode,
  input wire logic               rdata_valid,
  input wire logic               int_sel,
  input wire logic               cpu_reset,
  input wire logic               address_latch_strobe,
  input wire logic               data_transfer_strobe,
  input wire logic               rw_n,
  input wire logic               opcode_fetch_indicator,
  input wire logic [UPPER_W-1:0] upper_address_lines,
  input wire logic               muxed_low_addr_data_lines_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_as_one_in_five: assert property (address_latch_strobe |=> !address_latch_strobe [*4])
    else $error("address strobe repeats early");
  a_lowpower_freeze: assert property ((halt_mode || idle_mode) [*3] |-> !address_latch_strobe && !data_transfer_strobe)
    else $error("strobe runs in low power");
  a_ds_two_cycles: assert property ($rose(data_transfer_strobe) && !halt_mode && !idle_mode && !$past(halt_mode, 2)
    && !$past(idle_mode, 2) && !cpu_reset |=> data_transfer_strobe)
    else $error("data strobe too short");
  a_ds_not_three: assert property (data_transfer_strobe [*2] |=> !data_transfer_strobe)
    else $error("data strobe too long");
  a_addr_driven: assert property (address_latch_strobe |-> muxed_low_addr_data_lines_oe && !data_transfer_strobe)
    else $error("address phase not driven");
  a_read_release: assert property (data_transfer_strobe && rw_n |-> !muxed_low_addr_data_lines_oe)
    else $error("lines driven on read");
  a_write_drive: assert property (data_transfer_strobe && !rw_n |-> muxed_low_addr_data_lines_oe)
    else $error("lines released on write");
  a_dir_held: assert property ($rose(data_transfer_strobe) |-> $stable(rw_n) && $stable(upper_address_lines))
    else $error("direction or upper address moved");
  a_fetch_in_ds: assert property (opcode_fetch_indicator |-> data_transfer_strobe && rw_n)
    else $error("fetch flag outside read strobe");
  a_rdv_after_ds: assert property (rdata_valid |-> $past(data_transfer_strobe) && $past(rw_n))
    else $error("read data without read strobe");
  a_int_in_ds: assert property (int_sel |-> data_transfer_strobe)
    else $error("internal select outside data strobe");
  a_pin_reset: assert property ((!reset_pin_n) [*5] |-> cpu_reset)
    else $error("reset pin ignored");
endmodule : mcbi_bus_assertions
bind mcbi_bus mcbi_bus_assertions u_mcbi_bus_assertions (.*);

//--- bench/mcbi_ext_mem.sv
// external memory model on the multiplexed bus
// assumes the bus interface drives strobes; released lines show toggling junk
`timescale 1ns/100ps
module mcbi_ext_mem
  import mcbi_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               as_in,
  input  wire logic               ds_in,
  input  wire logic               rw_n,
  input  wire logic [UPPER_W-1:0] upper,
  input  wire logic [DATA_W-1:0]  bus_in,
  output logic      [DATA_W-1:0]  bus_out
);
  logic [DATA_W-1:0] mem [ADDR_SPACE];
  logic [ADDR_W-1:0] lat_addr = '0;
  logic [DATA_W-1:0] held = '0;
  initial foreach (mem[i]) mem[i] = DATA_W'(i * 3);
  // drive only in a read strobe; otherwise invert so stale data never looks valid
  assign bus_out = (ds_in && rw_n) ? mem[lat_addr] : ~held;
  always @(posedge clk) begin
    held <= bus_out;
    if (as_in) lat_addr <= {upper, bus_in};
    if (ds_in && !rw_n) mem[lat_addr] <= bus_in;
  end
endmodule : mcbi_ext_mem

//--- bench/tb.sv
// self-checking bench for mcbi_bus with an external memory model
// assumes 100 MHz clock and synchronous active-high reset
`timescale 1ns/100ps
module tb;
  import mcbi_pkg::*;
  logic clk = 0, sys_rst = 1, reset_pin_n = 1, halt_mode = 0, idle_mode = 0, req_valid = 0;
  logic req_ready, rdata_valid, int_sel, cpu_reset, als, dts, rw_n, ofi, oe;
  logic [DATA_W-1:0] rdata, int_rdata, lo_o, lo_i, ext, tb_lat = '0;
  logic [UPPER_W-1:0] up;
  logic [DATA_W-1:0] shadow [ADDR_SPACE];
  logic [DATA_W-1:0] exp_q [$];
  mcbi_req_s req = '0;
  int fail_count = 0, tests_run = 0;
  int fetch_seen = 0;
  initial forever #5 clk = ~clk;
  assign lo_i = oe ? lo_o : ext;
  // internal memory returns address xor a fixed pattern
  assign int_rdata = tb_lat ^ 8'h5a;
  always @(posedge clk) if (als) tb_lat <= lo_o;
  always @(posedge clk) if (ofi) fetch_seen++;
  mcbi_bus u_mcbi_bus (.clk(clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .halt_mode(halt_mode),
    .idle_mode(idle_mode), .req(req), .req_valid(req_valid), .req_ready(req_ready), .rdata(rdata),
    .rdata_valid(rdata_valid), .int_rdata(int_rdata), .int_sel(int_sel), .cpu_reset(cpu_reset),
    .address_latch_strobe(als), .data_transfer_strobe(dts), .rw_n(rw_n), .opcode_fetch_indicator(ofi),
    .upper_address_lines(up), .muxed_low_addr_data_lines_o(lo_o), .muxed_low_addr_data_lines_oe(oe),
    .muxed_low_addr_data_lines_i(lo_i));
  mcbi_ext_mem u_mcbi_ext_mem (.clk(clk), .as_in(als), .ds_in(dts), .rw_n(rw_n), .upper(up),
    .bus_in(lo_i), .bus_out(ext));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, want, seen);
    end
  endtask : check
  task automatic stop_test;
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  always @(posedge clk) if (rdata_valid) begin
    if (exp_q.size() == 0) check("extra_rdata", 8'h01, 8'h00);
    else check("rdata", rdata, exp_q.pop_front());
  end
  // called just after an edge; leaves valid high so back-to-back requests stay legal
  task automatic send(input logic [ADDR_W-1:0] a, input logic rd, input logic fe);
    mcbi_req_s r;
    r = '{a, rd, 8'($urandom), fe};
    if (rd) exp_q.push_back(a < INT_LIMIT ? a[7:0] ^ 8'h5a : shadow[a]);
    else shadow[a] = r.wdata;
    req = r;
    req_valid = 1;
    for (int n = 0; !req_ready; n++) begin
      if (n > 60) begin check("req_ready", 8'h00, 8'h01); stop_test(); end
      @(posedge clk); #1;
    end
    @(posedge clk); #1;
  endtask : send
  task automatic rest(input int n);
    req_valid = 0;
    repeat (n) @(posedge clk);
    #1;
  endtask : rest
  initial begin
    logic [ADDR_W-1:0] edges [4];
    logic rd;
    edges = '{13'h0080, 13'h1fff, 13'h007f, 13'h0000};
    foreach (shadow[i]) shadow[i] = DATA_W'(i * 3);
    void'($urandom(32'h992a));
    repeat (12) @(posedge clk);
    #1 sys_rst = 0;
    foreach (edges[k]) begin
      send(edges[k], 0, 0);
      send(edges[k], 1, k[0]);
    end
    repeat (40) begin
      rd = 1'($urandom);
      send(13'($urandom), rd, rd & 1'($urandom));
    end
    // let the fifo drain first, so exactly four halted requests fill it
    rest(30);
    halt_mode = 1;
    repeat (4) send(13'h0100 + 13'($urandom_range(0, 7)), 1, 0);
    rest(2);
    check("req_ready_full", {7'h00, req_ready}, 8'h00);
    halt_mode = 0;
    idle_mode = 1;
    rest(8);
    idle_mode = 0;
    rest(40);
    reset_pin_n = 0;
    rest(6);
    check("cpu_reset", {7'h00, cpu_reset}, 8'h01);
    reset_pin_n = 1;
    rest(10);
    send(13'h0080, 1, 1);
    rest(1);
    for (int n = 0; exp_q.size() != 0; n++) begin
      if (n > 200) begin check("drain", 8'h00, 8'h01); stop_test(); end
      @(posedge clk);
    end
    check("fetch_seen", {7'h00, fetch_seen != 0}, 8'h01);
    stop_test();
  end
endmodule : tb
